// ---- core/dac_core.sv ----
module dac_core (
    // Clock, enable and reset
    input  wire logic                sys_clk,
    input  wire logic                clk_en,
    input  wire logic                nrst,
    // Sampled inputs, two's complement LSB counts
    input  wire logic signed [7:0]   first_channel,
    input  wire logic signed [7:0]   second_channel,
    // Power selects
    input  wire logic                power_select_0,
    input  wire logic                power_select_1,
    // Reference select level classes
    input  wire logic                ref_level_high,
    input  wire logic                ref_level_low,
    // Sample bus and channel flag, tri-state as four signals
    output logic [7:0]               sample_bus,
    output logic                     sample_bus_oe,
    output logic                     chan_flag,
    output logic                     chan_flag_oe,
    // Status
    output logic [1:0]               power_mode,
    output logic [1:0]               ref_mode,
    output logic                     adc_powered,
    output logic                     ref_powered,
    output logic                     clkdist_powered
);
    localparam int L = dac_pkg::LAT_CYC;

    //--------------------------------------------------------------------
    // Functions
    //--------------------------------------------------------------------
    // Offset-binary conversion
    function automatic logic [7:0] to_offset(input logic signed [7:0] n);
        to_offset = n ^ dac_pkg::MIDSCALE;
    endfunction : to_offset

    //--------------------------------------------------------------------
    // State
    //--------------------------------------------------------------------
    // Pipeline, output and mode registers
    logic [7:0] pipe_a_ff [L];
    logic [7:0] pipe_b_ff [L];
    logic [7:0] nxt_pipe_a [L];
    logic [7:0] nxt_pipe_b [L];
    logic [7:0] word_b_ff, nxt_word_b;
    logic [7:0] out_a_ff, nxt_out_a;
    dac_pkg::dac_pmode_e mode_ff, nxt_mode;
    logic       adc_on;

    //--------------------------------------------------------------------
    // Power mode
    //--------------------------------------------------------------------
    // Mode decode from (select 0, select 1)
    always_comb begin
        case ({power_select_0, power_select_1})
            2'b00:   nxt_mode = dac_pkg::PM_SHUTDOWN;
            2'b01:   nxt_mode = dac_pkg::PM_STANDBY;
            2'b10:   nxt_mode = dac_pkg::PM_IDLE;
            2'b11:   nxt_mode = dac_pkg::PM_NORMAL;
            default: nxt_mode = dac_pkg::PM_SHUTDOWN;
        endcase
    end

    assign adc_on = (mode_ff == dac_pkg::PM_IDLE) ||
                    (mode_ff == dac_pkg::PM_NORMAL);

    //--------------------------------------------------------------------
    // Conversion pipeline
    //--------------------------------------------------------------------
    // Pipeline advance, holds last word while converters are off
    always_comb begin
        for (int i = 0; i < L; i++) begin
            nxt_pipe_a[i] = pipe_a_ff[i];
            nxt_pipe_b[i] = pipe_b_ff[i];
        end
        nxt_out_a  = out_a_ff;
        nxt_word_b = word_b_ff;
        if (adc_on) begin
            nxt_pipe_a[0] = to_offset(first_channel);
            nxt_pipe_b[0] = to_offset(second_channel);
            for (int i = 1; i < L; i++) begin
                nxt_pipe_a[i] = pipe_a_ff[i-1];
                nxt_pipe_b[i] = pipe_b_ff[i-1];
            end
            nxt_out_a  = pipe_a_ff[L-1];
            nxt_word_b = pipe_b_ff[L-1];
        end
    end

    //--------------------------------------------------------------------
    // Rising edge registers
    //--------------------------------------------------------------------
    // Register stage
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            for (int i = 0; i < L; i++) begin
                pipe_a_ff[i] <= dac_pkg::RST_WORD;
                pipe_b_ff[i] <= dac_pkg::RST_WORD;
            end
            out_a_ff  <= dac_pkg::RST_WORD;
            word_b_ff <= dac_pkg::RST_WORD;
            mode_ff   <= dac_pkg::PM_SHUTDOWN;
        end else if (clk_en) begin
            pipe_a_ff <= nxt_pipe_a;
            pipe_b_ff <= nxt_pipe_b;
            out_a_ff  <= nxt_out_a;
            word_b_ff <= nxt_word_b;
            mode_ff   <= nxt_mode;
        end
    end

    //--------------------------------------------------------------------
    // Falling edge register
    //--------------------------------------------------------------------
    // Second channel launched half a cycle later on the falling edge
    logic [7:0] out_b_ff;
    always_ff @(negedge sys_clk) begin
        if (!nrst) begin
            out_b_ff <= dac_pkg::RST_WORD;
        end else if (clk_en) begin
            out_b_ff <= word_b_ff;
        end
    end

    //--------------------------------------------------------------------
    // Output drive and status
    //--------------------------------------------------------------------
    // Bus mux: clock high shows first channel, low shows second
    always_comb begin
        sample_bus = sys_clk ? out_a_ff : out_b_ff;
        chan_flag  = sys_clk;
    end

    assign sample_bus_oe = (mode_ff == dac_pkg::PM_NORMAL);
    assign chan_flag_oe  = sample_bus_oe;
    assign power_mode    = mode_ff;
    assign adc_powered   = adc_on;
    assign ref_powered   = (mode_ff != dac_pkg::PM_SHUTDOWN);
    assign clkdist_powered = ref_powered;

    //--------------------------------------------------------------------
    // Reference mode
    //--------------------------------------------------------------------
    // Reference mode from level class
    always_comb begin
        if (ref_level_high)     ref_mode = dac_pkg::REF_INTERNAL;
        else if (ref_level_low) ref_mode = dac_pkg::REF_UNBUFFERED;
        else                    ref_mode = dac_pkg::REF_BUFFERED;
    end

    //--------------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------------

    // Seven running edges: one sampling edge plus the shifts behind it
    sequence s_run7;
        (clk_en && adc_on)[*7];
    endsequence : s_run7

    // Select pin patterns taken by an enabled edge
    sequence s_sel_shutdown;
        clk_en && !power_select_0 && !power_select_1;
    endsequence : s_sel_shutdown

    sequence s_sel_standby;
        clk_en && !power_select_0 && power_select_1;
    endsequence : s_sel_standby

    sequence s_sel_idle;
        clk_en && power_select_0 && !power_select_1;
    endsequence : s_sel_idle

    sequence s_sel_normal;
        clk_en && power_select_0 && power_select_1;
    endsequence : s_sel_normal

    // Converters stopped for one enabled edge
    sequence s_halted;
        clk_en && !adc_on;
    endsequence : s_halted

    // First channel word five cycles after its sample
    a_bus_latency: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        s_run7 |-> out_a_ff == to_offset($past(first_channel, 6)))
        else $error("first channel latency wrong");

    // Second channel word ready for the falling edge
    a_second_latency: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        s_run7 |-> word_b_ff == to_offset($past(second_channel, 6)))
        else $error("second channel latency wrong");

    // Falling edge stage takes the second word
    a_b_half: assert property (
        @(negedge sys_clk) disable iff (!nrst)
        clk_en |=> out_b_ff == $past(word_b_ff))
        else $error("second channel launch wrong");

    // High phase shows first word with flag high
    a_first_phase: assert property (
        @(negedge sys_clk) disable iff (!nrst)
        chan_flag && (sample_bus == out_a_ff))
        else $error("first phase bus wrong");

    // Low phase shows second word with flag low
    a_second_phase: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        !chan_flag && (sample_bus == out_b_ff))
        else $error("second phase bus wrong");

    // Sign of the input lands inverted on the top line
    a_msb_top: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        s_run7 |-> out_a_ff[7] == !$past(first_channel[7], 6))
        else $error("top bit wrong");

    // Bus released outside normal mode
    a_tri_state: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (mode_ff != dac_pkg::PM_NORMAL) |-> !sample_bus_oe)
        else $error("bus driven outside normal mode");

    // Bus and flag driven in normal mode
    a_drive_normal: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (mode_ff == dac_pkg::PM_NORMAL) |-> sample_bus_oe && chan_flag_oe)
        else $error("outputs not driven in normal mode");

    // Flag enable always matches bus enable
    a_oe_pair: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        sample_bus_oe == chan_flag_oe)
        else $error("flag enable differs from bus enable");

    // Shutdown powers everything down
    a_shutdown_off: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (mode_ff == dac_pkg::PM_SHUTDOWN) |->
            !adc_powered && !ref_powered && !clkdist_powered)
        else $error("shutdown leaves a section powered");

    // Standby keeps reference and clocks only
    a_standby_pwr: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (mode_ff == dac_pkg::PM_STANDBY) |->
            !adc_powered && ref_powered && !chan_flag_oe)
        else $error("standby power wrong");

    // Reference and clocks up outside shutdown
    a_ref_powered: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (mode_ff != dac_pkg::PM_SHUTDOWN) |-> ref_powered && clkdist_powered)
        else $error("reference or clocks off");

    // Idle powers all but keeps outputs off
    a_idle_pwr: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (mode_ff == dac_pkg::PM_IDLE) |->
            adc_powered && ref_powered && !sample_bus_oe)
        else $error("idle power wrong");

    // Held words survive while converters are off
    a_word_hold: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        s_halted |=> $stable(out_a_ff) && $stable(word_b_ff))
        else $error("word lost while unpowered");

    // Normal pattern decode into the mode register
    a_mode_map: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        s_sel_normal |=> mode_ff == dac_pkg::PM_NORMAL)
        else $error("mode decode wrong");

    // Shutdown pattern decode
    a_mode_shutdown: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        s_sel_shutdown |=> mode_ff == dac_pkg::PM_SHUTDOWN)
        else $error("shutdown decode wrong");

    // Standby pattern decode
    a_mode_standby: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        s_sel_standby |=> mode_ff == dac_pkg::PM_STANDBY)
        else $error("standby decode wrong");

    // Idle pattern decode
    a_mode_idle: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        s_sel_idle |=> mode_ff == dac_pkg::PM_IDLE)
        else $error("idle decode wrong");

    // High level picks the internal reference
    a_ref_internal: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        ref_level_high |-> ref_mode == dac_pkg::REF_INTERNAL)
        else $error("internal reference not chosen");

    // Grounded level picks the unbuffered reference
    a_ref_unbuffered: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        !ref_level_high && ref_level_low |->
            ref_mode == dac_pkg::REF_UNBUFFERED)
        else $error("unbuffered reference not chosen");

    // Middle level picks the buffered reference
    a_ref_buffered: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        !ref_level_high && !ref_level_low |->
            ref_mode == dac_pkg::REF_BUFFERED)
        else $error("buffered reference not chosen");
endmodule : dac_core

// ---- core/dac_pkg.sv ----
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package dac_pkg;
    // Sample width and offset-binary midscale
    localparam int          SAMPLE_W   = 8;
    localparam logic [7:0]  MIDSCALE   = 8'h80;
    localparam logic [7:0]  RST_WORD   = 8'h80;
    // Pipeline depth in full cycles before output latch
    localparam int          LAT_CYC    = 5;
    // Clock and wake-up times
    localparam int          CLK_NS     = 40;
    localparam int          WAKE_SD_NS = 20000;
    localparam int          WAKE_SB_NS = 5400;
    localparam int          WAKE_ID_NS = 5;
    localparam int          WAKE_SD_CYC = (WAKE_SD_NS + CLK_NS - 1) / CLK_NS;
    localparam int          WAKE_SB_CYC = (WAKE_SB_NS + CLK_NS - 1) / CLK_NS;
    localparam int          WAKE_ID_CYC = (WAKE_ID_NS + CLK_NS - 1) / CLK_NS;
    // Power modes
    typedef enum logic [1:0] {
        PM_SHUTDOWN,
        PM_STANDBY,
        PM_IDLE,
        PM_NORMAL
    } dac_pmode_e;
    // Reference modes
    typedef enum logic [1:0] {
        REF_INTERNAL,
        REF_BUFFERED,
        REF_UNBUFFERED
    } dac_ref_e;
endpackage : dac_pkg

// ---- verification/dac_host_model.sv ----
module dac_host_model (
    // Clock and sample bus from the converter
    input  wire logic       sys_clk,
    input  wire logic [7:0] sample_bus,
    input  wire logic       sample_bus_oe,
    input  wire logic       chan_flag,
    // Words and flags captured 5 ns into each phase
    output logic [7:0]      cap_first,
    output logic [7:0]      cap_second,
    output logic [1:0]      cap_flags
);
    timeunit 1ns;
    timeprecision 1ns;
    // High phase carries the first channel word
    always @(posedge sys_clk) begin
        #5 if (sample_bus_oe) begin
            cap_first = sample_bus;
            cap_flags[1] = chan_flag;
        end
    end
    // Low phase carries the second channel word
    always @(negedge sys_clk) begin
        #5 if (sample_bus_oe) begin
            cap_second = sample_bus;
            cap_flags[0] = chan_flag;
        end
    end
endmodule : dac_host_model

// ---- verification/testbench.sv ----
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic              sys_clk = 0, nrst = 0, ps0 = 0, ps1 = 0;
    logic              rh = 1, rl = 0, oe, fl, foe, ap, rp, cp;
    logic              ce = 1;
    logic signed [7:0] fa = 0, sa = 0;
    logic [7:0]        bus, cf, cs;
    logic [1:0]        pm, rm, cfl;
    int                fails = 0, total_checks = 0;
    dac_core dut (.sys_clk, .clk_en(ce), .nrst, .first_channel(fa),
        .second_channel(sa), .power_select_0(ps0), .power_select_1(ps1),
        .ref_level_high(rh), .ref_level_low(rl), .sample_bus(bus),
        .sample_bus_oe(oe), .chan_flag(fl), .chan_flag_oe(foe),
        .power_mode(pm), .ref_mode(rm), .adc_powered(ap),
        .ref_powered(rp), .clkdist_powered(cp));
    dac_host_model host (.sys_clk, .sample_bus(bus), .sample_bus_oe(oe),
        .chan_flag(fl), .cap_first(cf), .cap_second(cs), .cap_flags(cfl));
    // Even duty clock
    initial forever #20 sys_clk = ~sys_clk;
    task chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task report_and_stop;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop
    task set_mode(input logic [1:0] m);
        @(negedge sys_clk);
        {ps0, ps1} = m;
        repeat (2) @(negedge sys_clk);
    endtask : set_mode
    // Every mode with its power status, plus reference classes
    task test_modes;
        for (int m = 0; m < 4; m++) begin
            set_mode(2'(m));
            rh = (m % 3 == 0);
            rl = (m % 3 == 2);
            #1 chk(rm, 8'(m % 3));
            chk(pm, 8'(m));
            chk({ap, rp, cp}, {m > 1, m > 0, m > 0});
            chk({oe, foe}, {2{m == 3}});
        end
        rh = 1;
        rl = 0;
        $display("test_modes done");
    endtask : test_modes
    // Back-to-back pairs spanning full scale, latency per channel
    task test_stream;
        logic signed [7:0] va [16];
        logic signed [7:0] vb [16];
        for (int j = 0; j < 16; j++) begin
            va[j] = 8'(j * 17 - 128);
            vb[j] = 8'(127 - j * 17);
        end
        for (int j = 0; j < 16; j++) begin
            @(negedge sys_clk);
            fa = va[j];
            sa = vb[j];
            #10 if (j >= 6) chk(cs, vb[j-6] + 8'd128);
            if (j >= 6) chk(cfl, 8'h2);
            @(posedge sys_clk);
            #10 if (j >= 5) chk(cf, va[j-5] + 8'd128);
        end
        $display("test_stream done");
    endtask : test_stream
    // Standby then wake shows the last converted words
    task test_rewake;
        @(negedge sys_clk);
        fa = -8'sd3;
        sa = 8'sd9;
        repeat (8) @(negedge sys_clk);
        set_mode(2'h1);
        fa = 0;
        sa = 0;
        repeat (4) @(negedge sys_clk);
        set_mode(2'h3);
        chk(cf, 8'h7D);
        chk(cs, 8'h89);
        $display("test_rewake done");
    endtask : test_rewake
    // Leave a power-down mode, use data once the wake time is over
    task wake_from(input logic [1:0] m, input int cyc,
                   input logic signed [7:0] a, input logic signed [7:0] b);
        set_mode(m);
        fa = a;
        sa = b;
        set_mode(2'h3);
        repeat (cyc + dac_pkg::LAT_CYC + 1) @(negedge sys_clk);
        chk(cf, a + 8'd128);
        chk(cs, b + 8'd128);
        $display("wake_from done");
    endtask : wake_from
    // Clock enable low freezes the held words
    task test_freeze;
        @(negedge sys_clk);
        ce = 0;
        fa = 8'sd55;
        sa = -8'sd55;
        repeat (8) @(negedge sys_clk);
        chk(cf, 8'h80);
        chk(cs, 8'h7F);
        ce = 1;
        repeat (8) @(negedge sys_clk);
        chk(cf, 8'hB7);
        chk(cs, 8'h49);
        $display("test_freeze done");
    endtask : test_freeze
    initial begin
        repeat (10) @(negedge sys_clk);
        nrst = 1;
        test_modes;
        test_stream;
        test_rewake;
        wake_from(2'h0, dac_pkg::WAKE_SD_CYC, 8'sd100, -8'sd100);
        wake_from(2'h1, dac_pkg::WAKE_SB_CYC, -8'sd128, 8'sd127);
        wake_from(2'h2, dac_pkg::WAKE_ID_CYC, 8'sd0, -8'sd1);
        test_freeze;
        report_and_stop;
    end
    // Watchdog about twice the expected run
    initial begin
        #60000 fails++;
        report_and_stop;
    end
endmodule : testbench
